// ===== pkg/fmb_pkg.sv
// constants, encodings and helper functions shared by the mailbox fifo block
package fmb_pkg;
    localparam int FMB_DEPTH = 64;
    localparam int FMB_WIDTH = 36;
    localparam int FMB_PTR_W = 7;
    localparam int FMB_BYTE_W = 9;
    localparam int FMB_NBYTES = 4;
    localparam logic [6:0] FMB_DEPTH_CNT = 7'h40;

    // almost-full / almost-empty offsets picked by the two strap inputs at reset release
    localparam logic [6:0] FMB_THR_PRESET0 = 7'h04;
    localparam logic [6:0] FMB_THR_PRESET1 = 7'h08;
    localparam logic [6:0] FMB_THR_PRESET2 = 7'h10;
    localparam logic [6:0] FMB_THR_PRESET3 = 7'h20;

    // port b width select encoding {select_1, select_0}
    localparam logic [1:0] FMB_SIZ_LONG = 2'h0;
    localparam logic [1:0] FMB_SIZ_BYTE = 2'h1;
    localparam logic [1:0] FMB_SIZ_WORD = 2'h2;
    localparam logic [1:0] FMB_SIZ_MAIL = 2'h3;

    // swap modes {swap_1, swap_0}
    localparam logic [1:0] FMB_SW_NONE = 2'h0;
    localparam logic [1:0] FMB_SW_BYTE = 2'h1;
    localparam logic [1:0] FMB_SW_WORD = 2'h2;
    localparam logic [1:0] FMB_SW_BYTEWORD = 2'h3;

    // ahb register map
    localparam logic [31:0] FMB_REG_CTRL = 32'h0000_0000;
    localparam logic [31:0] FMB_REG_STATUS = 32'h0000_0004;
    localparam logic [31:0] FMB_REG_LEVEL = 32'h0000_0008;
    localparam int FMB_CTRL_ODD_BIT = 0;
    localparam logic FMB_CTRL_ODD_RST = 1'b1;
    localparam int FMB_LEVEL_THR_POS = 8;

    localparam logic [35:0] FMB_ZERO36 = 36'h0_0000_0000;

    function automatic logic [35:0] fmb_swap(input logic [35:0] w, input logic [1:0] mode);
        case (mode)
            FMB_SW_BYTE: fmb_swap = {w[8:0], w[17:9], w[26:18], w[35:27]};
            FMB_SW_WORD: fmb_swap = {w[17:0], w[35:18]};
            FMB_SW_BYTEWORD: fmb_swap = {w[26:18], w[35:27], w[8:0], w[17:9]};
            default: fmb_swap = w;
        endcase
    endfunction

    // rewrite the top bit of every 9-bit byte with generated parity
    function automatic logic [35:0] fmb_gen_par(input logic [35:0] w, input logic odd);
        logic [35:0] r;
        r = w;
        for (int i = 0; i < FMB_NBYTES; i++) begin
            r[i*FMB_BYTE_W+8] = (^w[i*FMB_BYTE_W +: 8]) ^ odd;
        end
        fmb_gen_par = r;
    endfunction

    // per-byte parity check result, one bit per byte, high when the byte passes
    function automatic logic [3:0] fmb_chk_par(input logic [35:0] w, input logic odd);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < FMB_NBYTES; i++) begin
            r[i] = ((^w[i*FMB_BYTE_W +: FMB_BYTE_W]) == odd);
        end
        fmb_chk_par = r;
    endfunction
endpackage

// ===== src/fmb_top.sv
// 64x36 fifo with two mailboxes, port b bus matching, parity and an ahb-lite control slave
`timescale 1ns/10ps

// Functional notes
// [RULE1] 64x36 store, written by A, read by B
// [RULE2] port clocks independent, asynchronous or coincident
// [RULE3] A access needs select low, qualifier high
// [RULE4] B access needs select low, qualifier high
// [RULE5] data drivers released while select high
// [RULE6] direction high writes, low reads, releases bus
// [RULE7] full/empty flags two-stage synced to ports
// [RULE8] almost-empty low when count at/below threshold
// [RULE9] almost-full low when free at/below threshold
// [RULE10] empty low blocks reads, rises second B edge
// [RULE11] full low blocks writes, rises after reset
// [RULE12] threshold straps captured at reset release
// [RULE13] A mailbox choose targets mailboxes, outputs mail two
// [RULE14] A mailbox write drops flag one, blocks rewrites
// [RULE15] B mailbox read raises flag one
// [RULE16] B mailbox write drops flag two, blocks rewrites
// [RULE17] A mailbox read raises flag two
// [RULE18] B widths long, word, byte, either endianness
// [RULE19] width latched one edge, applied next edge
// [RULE20] lane select low uses msb lanes
// [RULE21] swapping and sizing on B clock edges
// [RULE22] swap mode chosen at each long-word start
// [RULE23] parity sense picks odd or even
// [RULE24] A parity error low on failing byte
// [RULE25] A parity error forced high on generated read
// [RULE26] A mailbox read regenerates byte parity
// [RULE27] A FIFO write stores and advances pointer
// [RULE28] B FIFO read sizes data, advances per word
module fmb_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic port_a_clock,
    input wire logic port_a_select_n,
    input wire logic port_a_access_qualifier,
    input wire logic port_a_direction,
    input wire logic port_a_mailbox_choose,
    input wire logic port_a_parity_generate,
    input wire logic [fmb_pkg::FMB_WIDTH-1:0] port_a_data_in,
    output logic [fmb_pkg::FMB_WIDTH-1:0] port_a_data_out,
    output logic port_a_data_oe_n,
    output logic port_a_parity_error_n,
    output logic full_flag_n,
    output logic almost_full_flag_n,
    output logic mail_one_flag_n,
    input wire logic port_b_clock,
    input wire logic port_b_select_n,
    input wire logic port_b_access_qualifier,
    input wire logic port_b_direction,
    input wire logic bus_width_select_0,
    input wire logic bus_width_select_1,
    input wire logic msb_lane_select,
    input wire logic lane_swap_select_0,
    input wire logic lane_swap_select_1,
    input wire logic port_b_parity_generate,
    input wire logic [fmb_pkg::FMB_WIDTH-1:0] port_b_data_in,
    output logic [fmb_pkg::FMB_WIDTH-1:0] port_b_data_out,
    output logic port_b_data_oe_n,
    output logic port_b_parity_error_n,
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic mail_two_flag_n,
    input wire logic flag_threshold_select_0,
    input wire logic flag_threshold_select_1
);
    import fmb_pkg::*;

    logic a_prev_ff, b_prev_ff;
    logic [FMB_PTR_W-1:0] wr_ptr_ff, rd_ptr_ff;
    logic [FMB_WIDTH-1:0] mem_ff [FMB_DEPTH];
    logic [FMB_WIDTH-1:0] mail_one_ff, mail_two_ff, b_hold_ff, b_out_ff, a_out_ff;
    logic full_s1_ff, full_ff, afull_s1_ff, afull_ff;
    logic empty_s1_ff, empty_ff, aempty_s1_ff, aempty_ff;
    logic mail_one_ff_n, mail_two_ff_n;
    logic thr_done_ff;
    logic [6:0] thr_ff;
    logic [2:0] b_siz_lat_ff;
    logic [1:0] b_sub_ff, b_sw_ff;
    logic pe_a_ff, pe_b_ff;
    logic ctrl_odd_ff;
    logic ap_valid_ff, ap_write_ff;
    logic [31:0] ap_addr_ff, hrdata_ff;

    // port clocks arrive as synchronous inputs; each rising edge becomes a one-cycle enable
    wire a_edge = port_a_clock & ~a_prev_ff; // [RULE2]
    wire b_edge = port_b_clock & ~b_prev_ff; // [RULE2]
    wire odd = ctrl_odd_ff;

    // port a decode
    wire a_sel = ~port_a_select_n & port_a_access_qualifier; // [RULE3]
    wire a_wr = a_edge & a_sel & port_a_direction; // [RULE6]
    wire a_rd = a_edge & a_sel & ~port_a_direction; // [RULE6]
    wire a_mb_wr = a_wr & port_a_mailbox_choose & mail_one_ff_n; // [RULE13] [RULE14]
    wire a_mb_rd = a_rd & port_a_mailbox_choose; // [RULE13]
    wire a_fifo_req = a_wr & ~port_a_mailbox_choose;
    wire a_fifo_wr = a_fifo_req & full_ff; // [RULE11] [RULE27]

    // port b decode; mailbox choice follows the live width selects
    wire [1:0] b_siz_now = {bus_width_select_1, bus_width_select_0};
    wire b_sel = ~port_b_select_n & port_b_access_qualifier; // [RULE4]
    wire b_is_mail = (b_siz_now == FMB_SIZ_MAIL);
    wire b_mb_rd = b_edge & b_sel & ~port_b_direction & b_is_mail; // [RULE15]
    wire b_mb_wr = b_edge & b_sel & port_b_direction & b_is_mail & mail_two_ff_n; // [RULE16]
    wire b_fifo_req = b_edge & b_sel & ~port_b_direction & ~b_is_mail;
    wire b_fifo_rd = b_fifo_req & empty_ff; // [RULE10] [RULE28]

    // width and endianness in force were latched at the previous port b edge
    wire [1:0] b_siz = b_siz_lat_ff[1:0]; // [RULE19]
    wire b_little = b_siz_lat_ff[2];
    wire [1:0] b_last = (b_siz == FMB_SIZ_BYTE) ? 2'h3 :
                        (b_siz == FMB_SIZ_WORD) ? 2'h1 : 2'h0;
    wire b_word_done = b_fifo_rd & (b_sub_ff == b_last); // [RULE28]

    // occupancy, computed in one place so flags and pointers agree
    wire [6:0] count = wr_ptr_ff - rd_ptr_ff;
    wire [6:0] cnt_after_wr = count + {6'h00, a_fifo_wr};
    wire [6:0] cnt_after_rd = count - {6'h00, b_word_done};
    wire [6:0] free_after_wr = FMB_DEPTH_CNT - cnt_after_wr;
    wire not_full_nxt = (cnt_after_wr != FMB_DEPTH_CNT);
    wire not_afull_nxt = (free_after_wr > thr_ff); // [RULE9]
    wire not_empty_nxt = (cnt_after_rd != 7'h00);
    wire not_aempty_nxt = (cnt_after_rd > thr_ff); // [RULE8]

    // read data path: swap at the start of a long word, then pick the piece
    wire [1:0] sw_now = {lane_swap_select_1, lane_swap_select_0};
    wire [35:0] head_word = mem_ff[rd_ptr_ff[5:0]];
    wire [35:0] b_src = (b_sub_ff == 2'h0) ? fmb_swap(head_word, sw_now) : b_hold_ff; // [RULE22]
    wire b_half = b_little ? b_sub_ff[0] : ~b_sub_ff[0]; // [RULE20]
    wire [1:0] b_bidx = b_little ? b_sub_ff : 2'h3 - b_sub_ff; // [RULE20]
    wire [17:0] piece18 = b_half ? b_src[35:18] : b_src[17:0];
    wire [8:0] piece9 = b_src[b_bidx*FMB_BYTE_W +: FMB_BYTE_W];
    wire [35:0] b_word_lanes = b_little ? {18'h0_0000, piece18} : {piece18, 18'h0_0000}; // [RULE20]
    wire [35:0] b_byte_lanes = b_little ? {27'h000_0000, piece9} : {piece9, 27'h000_0000}; // [RULE20]
    wire [35:0] b_placed = (b_siz == FMB_SIZ_WORD) ? b_word_lanes :
                           (b_siz == FMB_SIZ_BYTE) ? b_byte_lanes : b_src; // [RULE18]
    wire [35:0] b_fifo_out = port_b_parity_generate ? fmb_gen_par(b_placed, odd) : b_placed;
    wire [35:0] b_mail_out = port_b_parity_generate ? fmb_gen_par(mail_one_ff, odd) : mail_one_ff;

    // parity checking; the trees are shared with generation, hence the forced-high cases
    wire a_pg_setup = ~port_a_select_n & port_a_access_qualifier & ~port_a_direction &
                      port_a_mailbox_choose & port_a_parity_generate;
    wire b_pg_setup = ~port_b_select_n & port_b_access_qualifier & ~port_b_direction &
                      b_is_mail & port_b_parity_generate;
    wire [3:0] a_par_ok = fmb_chk_par(port_a_data_in, odd); // [RULE23]
    wire [3:0] b_par_ok = fmb_chk_par(port_b_data_in, odd); // [RULE23]
    wire [3:0] b_valid = (b_siz == FMB_SIZ_WORD) ? (b_little ? 4'h3 : 4'hc) :
                         (b_siz == FMB_SIZ_BYTE) ? (b_little ? 4'h1 : 4'h8) : 4'hf;

    // ahb decode
    wire ap_take = hsel & htrans[1] & hready;
    wire dp_write = ap_valid_ff & ap_write_ff;
    wire [31:0] status_word = {26'h000_0000, mail_two_ff_n, mail_one_ff_n,
                               afull_ff, full_ff, aempty_ff, empty_ff};
    wire [31:0] level_word = {17'h0_0000, thr_ff, 1'b0, count};
    wire [31:0] rd_value = (haddr == FMB_REG_CTRL) ? {31'h0000_0000, ctrl_odd_ff} :
                           (haddr == FMB_REG_STATUS) ? status_word :
                           (haddr == FMB_REG_LEVEL) ? level_word : 32'h0000_0000;
    wire [6:0] thr_pick = ({flag_threshold_select_1, flag_threshold_select_0} == 2'h0) ?
                          FMB_THR_PRESET0 :
                          ({flag_threshold_select_1, flag_threshold_select_0} == 2'h1) ?
                          FMB_THR_PRESET1 :
                          ({flag_threshold_select_1, flag_threshold_select_0} == 2'h2) ?
                          FMB_THR_PRESET2 : FMB_THR_PRESET3;

    wire [FMB_PTR_W-1:0] nxt_wr_ptr = wr_ptr_ff + {6'h00, a_fifo_wr};
    wire [FMB_PTR_W-1:0] nxt_rd_ptr = rd_ptr_ff + {6'h00, b_word_done};

    assign hrdata = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign port_a_data_out = a_out_ff;
    assign port_b_data_out = b_out_ff;
    assign port_a_data_oe_n = port_a_select_n | port_a_direction; // [RULE5] [RULE6]
    assign port_b_data_oe_n = port_b_select_n | port_b_direction; // [RULE5] [RULE6]
    assign port_a_parity_error_n = pe_a_ff;
    assign port_b_parity_error_n = pe_b_ff;
    assign full_flag_n = full_ff;
    assign almost_full_flag_n = afull_ff;
    assign empty_flag_n = empty_ff;
    assign almost_empty_flag_n = aempty_ff;
    assign mail_one_flag_n = mail_one_ff_n;
    assign mail_two_flag_n = mail_two_ff_n;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_prev_ff <= 1'b1;
            b_prev_ff <= 1'b1;
        end else begin
            a_prev_ff <= port_a_clock;
            b_prev_ff <= port_b_clock;
        end
    end

    // storage written one entry per slot
    genvar gi;
    generate
        for (gi = 0; gi < FMB_DEPTH; gi++) begin : g_mem
            always_ff @(posedge hclk) begin
                if (a_fifo_wr && (wr_ptr_ff[5:0] == 6'(gi))) begin // [RULE1] [RULE27]
                    mem_ff[gi] <= port_a_data_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_ff <= 7'h00;
            rd_ptr_ff <= 7'h00;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr; // [RULE27]
            rd_ptr_ff <= nxt_rd_ptr; // [RULE28]
        end
    end

    // flags fall on the edge that causes them, but rise only after two port edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_s1_ff <= 1'b0;
            full_ff <= 1'b0;
            afull_s1_ff <= 1'b1;
            afull_ff <= 1'b1;
        end else if (a_edge) begin
            full_s1_ff <= not_full_nxt; // [RULE7]
            full_ff <= not_full_nxt & full_s1_ff; // [RULE7] [RULE11]
            afull_s1_ff <= not_afull_nxt;
            afull_ff <= not_afull_nxt & afull_s1_ff; // [RULE9]
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_s1_ff <= 1'b0;
            empty_ff <= 1'b0;
            aempty_s1_ff <= 1'b0;
            aempty_ff <= 1'b0;
        end else if (b_edge) begin
            empty_s1_ff <= not_empty_nxt; // [RULE7]
            empty_ff <= not_empty_nxt & empty_s1_ff; // [RULE7] [RULE10]
            aempty_s1_ff <= not_aempty_nxt;
            aempty_ff <= not_aempty_nxt & aempty_s1_ff; // [RULE8]
        end
    end

    // straps are sampled by the first clock after reset release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thr_done_ff <= 1'b0;
            thr_ff <= FMB_THR_PRESET0;
        end else if (!thr_done_ff) begin
            thr_done_ff <= 1'b1;
            thr_ff <= thr_pick; // [RULE12]
        end
    end

    // a new write beats a release in the same cycle so mail is never lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mail_one_ff_n <= 1'b1;
            mail_two_ff_n <= 1'b1;
            mail_one_ff <= FMB_ZERO36;
            mail_two_ff <= FMB_ZERO36;
        end else begin
            if (a_mb_wr) begin
                mail_one_ff <= port_a_data_in; // [RULE14]
                mail_one_ff_n <= 1'b0; // [RULE14]
            end else if (b_mb_rd) begin
                mail_one_ff_n <= 1'b1; // [RULE15]
            end
            if (b_mb_wr) begin
                mail_two_ff <= port_b_data_in; // [RULE16]
                mail_two_ff_n <= 1'b0; // [RULE16]
            end else if (a_mb_rd) begin
                mail_two_ff_n <= 1'b1; // [RULE17]
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            b_siz_lat_ff <= {1'b0, FMB_SIZ_LONG};
            b_sub_ff <= 2'h0;
            b_sw_ff <= FMB_SW_NONE;
            b_hold_ff <= FMB_ZERO36;
            b_out_ff <= FMB_ZERO36;
        end else if (b_edge) begin
            b_siz_lat_ff <= {msb_lane_select, b_siz_now}; // [RULE19] [RULE21]
            if (b_mb_rd) begin
                b_out_ff <= b_mail_out;
            end else if (b_fifo_rd) begin
                b_out_ff <= b_fifo_out; // [RULE18] [RULE21]
                b_sub_ff <= b_word_done ? 2'h0 : b_sub_ff + 2'h1;
                if (b_sub_ff == 2'h0) begin
                    b_hold_ff <= b_src; // [RULE22]
                    b_sw_ff <= sw_now;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_out_ff <= FMB_ZERO36;
            pe_a_ff <= 1'b1;
            pe_b_ff <= 1'b1;
        end else begin
            a_out_ff <= port_a_parity_generate ? fmb_gen_par(mail_two_ff, odd) : mail_two_ff; // [RULE13] [RULE26]
            pe_a_ff <= a_pg_setup | (&a_par_ok); // [RULE24] [RULE25]
            pe_b_ff <= b_pg_setup | (&(b_par_ok | ~b_valid));
        end
    end

    // zero-wait ahb-lite slave; read data is registered during the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid_ff <= 1'b0;
            ap_write_ff <= 1'b0;
            ap_addr_ff <= 32'h0000_0000;
            hrdata_ff <= 32'h0000_0000;
            ctrl_odd_ff <= FMB_CTRL_ODD_RST;
        end else begin
            ap_valid_ff <= ap_take;
            ap_write_ff <= hwrite;
            ap_addr_ff <= haddr;
            if (ap_take && !hwrite) begin
                hrdata_ff <= rd_value;
            end
            if (dp_write && (ap_addr_ff == FMB_REG_CTRL)) begin
                ctrl_odd_ff <= hwdata[FMB_CTRL_ODD_BIT]; // [RULE23]
            end
        end
    end

    a_wr_blocked: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
        (a_fifo_req && !full_flag_n) |=> $stable(wr_ptr_ff))
        else $error("fifo write taken while full");
    a_rd_blocked: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
        (b_fifo_req && !empty_flag_n) |=> $stable(rd_ptr_ff))
        else $error("fifo read taken while empty");
    a_mail_one_set: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
        (a_wr && port_a_mailbox_choose && mail_one_flag_n) |=>
        (!mail_one_flag_n && mail_one_ff == $past(port_a_data_in)))
        else $error("mailbox one write not captured");
    a_mail_one_free: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE15]
        (b_mb_rd && !a_mb_wr) |=> mail_one_flag_n)
        else $error("mailbox one flag not released");
    a_mail_two_hold: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE16]
        (!mail_two_flag_n && !a_mb_rd) |=> ($stable(mail_two_ff) && !mail_two_flag_n))
        else $error("mailbox two changed while full");
    a_mail_two_free: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE17]
        (a_mb_rd && !b_mb_wr) |=> mail_two_flag_n)
        else $error("mailbox two flag not released");
    a_aempty_level: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE8]
        almost_empty_flag_n |-> (count > thr_ff))
        else $error("almost empty high at or below threshold");
    a_afull_level: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE9]
        almost_full_flag_n |-> ((FMB_DEPTH_CNT - count) > thr_ff))
        else $error("almost full high at or below free threshold");
    a_empty_rise: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE10]
        (b_edge && !empty_flag_n && !empty_s1_ff && count != 7'h00 && !b_word_done) |=>
        (!empty_flag_n && empty_s1_ff))
        else $error("empty flag rose before second port b edge");
endmodule

// ===== tb/fmb_host.sv
// far-side port host model: makes one port clock rise per call
`timescale 1ns/10ps
module fmb_host (
    input wire logic hclk,
    output logic clk_out
);
    initial clk_out = 1'b1;
    // the low level lasts one hclk cycle and the high level at least two, so the edge sampler cannot miss it
    task automatic pulse();
        @(posedge hclk);
        clk_out <= 1'b0;
        @(posedge hclk);
        clk_out <= 1'b1;
        repeat (2) @(posedge hclk);
        #1;
    endtask
endmodule

// ===== tb/tb.sv
// self-checking bench: fifo, sizing, mailboxes, parity and register slave
`timescale 1ns/10ps
module tb;
    import fmb_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, sw;
    logic [2:0] hsize;
    logic port_a_clock, port_a_select_n, port_a_access_qualifier, port_a_direction;
    logic port_a_mailbox_choose, port_a_parity_generate, port_a_data_oe_n;
    logic port_a_parity_error_n, full_flag_n, almost_full_flag_n, mail_one_flag_n;
    logic port_b_clock, port_b_select_n, port_b_access_qualifier, port_b_direction;
    logic bus_width_select_0, bus_width_select_1, msb_lane_select, lane_swap_select_0;
    logic lane_swap_select_1, port_b_parity_generate, port_b_data_oe_n, port_b_parity_error_n;
    logic empty_flag_n, almost_empty_flag_n, mail_two_flag_n;
    logic flag_threshold_select_0, flag_threshold_select_1;
    logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out, w, m;
    logic [35:0] q[$];
    int num_errors = 0;
    int n_compared = 0;
    assign hready = hreadyout;
    fmb_top uut (.*);
    fmb_host ha (.hclk(hclk), .clk_out(port_a_clock));
    fmb_host hb (.hclk(hclk), .clk_out(port_b_clock));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic pa(input logic wr, input logic mb, input logic qe, input logic [35:0] d);
        @(posedge hclk);
        port_a_select_n <= 1'b0;
        port_a_access_qualifier <= qe;
        port_a_direction <= wr;
        port_a_mailbox_choose <= mb;
        port_a_data_in <= d;
        ha.pulse();
        port_a_select_n <= 1'b1;
    endtask
    task automatic pb(input logic wr, input logic cs_n, input logic [1:0] sz, input logic ln,
            input logic [1:0] s, input logic [35:0] d);
        @(posedge hclk);
        port_b_select_n <= cs_n;
        port_b_access_qualifier <= 1'b1;
        port_b_direction <= wr;
        {bus_width_select_1, bus_width_select_0} <= sz;
        msb_lane_select <= ln;
        {lane_swap_select_1, lane_swap_select_0} <= s;
        port_b_data_in <= d;
        hb.pulse();
        port_b_select_n <= 1'b1;
    endtask
    task automatic st();
        repeat (2) @(posedge hclk);
        #1;
    endtask
    function automatic logic [35:0] swp(input logic [35:0] x, input logic [1:0] s);
        case (s)
            2'h1: return {x[8:0], x[17:9], x[26:18], x[35:27]};
            2'h2: return {x[17:0], x[35:18]};
            2'h3: return {x[26:18], x[35:27], x[8:0], x[17:9]};
            default: return x;
        endcase
    endfunction
    // odd parity in the top bit of each byte
    function automatic logic [35:0] podd(input logic [35:0] x);
        for (int i = 0; i < 4; i++) x[9*i+8] = ~^x[9*i +: 8];
        return x;
    endfunction
    task automatic print_verdict();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        num_errors++;
        print_verdict();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {port_a_select_n, port_b_select_n} = 2'h3;
        {port_a_access_qualifier, port_a_direction, port_a_mailbox_choose,
            port_a_parity_generate, port_a_data_in} = '0;
        {port_b_access_qualifier, port_b_direction, bus_width_select_0, bus_width_select_1,
            msb_lane_select, lane_swap_select_0, lane_swap_select_1, port_b_parity_generate,
            port_b_data_in, flag_threshold_select_0, flag_threshold_select_1} = '0;
        void'($urandom(32'h33036753));
        repeat (20) @(posedge hclk);
        chk({full_flag_n, empty_flag_n}, 2'h0);
        chk({mail_one_flag_n, mail_two_flag_n}, 2'h3);
        hresetn <= 1'b1;
        ha.pulse();
        ha.pulse();
        chk({full_flag_n, almost_full_flag_n}, 2'h3);
        ahb(1'b0, FMB_REG_CTRL, '0);
        chk(rd, 36'h1);
        ahb(1'b0, 32'h0000_0040, '0);
        chk(rd, 36'h0);
        $display("reset test done");
        for (int i = 0; i < 65; i++) begin
            w = 36'({$urandom(), $urandom()});
            pa(1'b1, 1'b0, 1'b1, w);
            if (i < 64) q.push_back(w);
        end
        chk({full_flag_n, almost_full_flag_n}, 2'h0);
        ahb(1'b0, FMB_REG_LEVEL, '0);
        chk(rd[6:0], 7'h40);
        chk(rd[14:8], FMB_THR_PRESET0);
        pb(1'b0, 1'b1, FMB_SIZ_LONG, 1'b0, 2'h0, '0);
        pb(1'b0, 1'b1, FMB_SIZ_LONG, 1'b0, 2'h0, '0);
        chk({empty_flag_n, almost_empty_flag_n}, 2'h3);
        while (q.size() > 0) begin
            sw = 2'($urandom());
            m = swp(q.pop_front(), sw);
            pb(1'b0, 1'b0, FMB_SIZ_LONG, 1'b0, sw, '0);
            chk(port_b_data_out, m);
        end
        chk({empty_flag_n, almost_empty_flag_n}, 2'h0);
        pb(1'b0, 1'b0, FMB_SIZ_LONG, 1'b0, 2'h0, '0);
        chk(port_b_data_out, m);
        $display("fifo test done");
        // full only rises on the second port a edge after the reads drained it
        ha.pulse();
        ha.pulse();
        chk(full_flag_n, 1'b1);
        w = 36'({$urandom(), $urandom()});
        pa(1'b1, 1'b0, 1'b1, w);
        pb(1'b0, 1'b1, FMB_SIZ_WORD, 1'b0, 2'h0, '0);
        pb(1'b0, 1'b1, FMB_SIZ_WORD, 1'b0, 2'h0, '0);
        for (int i = 1; i >= 0; i--) begin
            pb(1'b0, 1'b0, FMB_SIZ_WORD, 1'b0, 2'h0, '0);
            chk(port_b_data_out, {w[18*i +: 18], 18'h0_0000});
        end
        w = 36'({$urandom(), $urandom()});
        pa(1'b1, 1'b0, 1'b1, w);
        pb(1'b0, 1'b1, FMB_SIZ_BYTE, 1'b1, 2'h0, '0);
        pb(1'b0, 1'b1, FMB_SIZ_BYTE, 1'b1, 2'h0, '0);
        for (int i = 0; i < 4; i++) begin
            pb(1'b0, 1'b0, FMB_SIZ_BYTE, 1'b1, 2'h0, '0);
            chk(port_b_data_out, {27'h000_0000, w[9*i +: 9]});
        end
        chk(empty_flag_n, 1'b0);
        $display("sizing test done");
        w = 36'({$urandom(), $urandom()});
        m = 36'({$urandom(), $urandom()});
        pa(1'b1, 1'b1, 1'b0, w);
        chk(mail_one_flag_n, 1'b1);
        pa(1'b1, 1'b1, 1'b1, w);
        chk(mail_one_flag_n, 1'b0);
        pa(1'b1, 1'b1, 1'b1, m);
        pb(1'b0, 1'b0, FMB_SIZ_MAIL, 1'b0, 2'h0, '0);
        chk({port_b_data_out, mail_one_flag_n}, {w, 1'b1});
        pb(1'b1, 1'b0, FMB_SIZ_MAIL, 1'b0, 2'h0, m);
        pb(1'b1, 1'b0, FMB_SIZ_MAIL, 1'b0, 2'h0, w);
        chk({port_a_data_out, mail_two_flag_n}, {m, 1'b0});
        pa(1'b0, 1'b1, 1'b1, '0);
        chk(mail_two_flag_n, 1'b1);
        $display("mailbox test done");
        w = podd(36'({$urandom(), $urandom()}));
        port_a_data_in <= w;
        port_b_data_in <= podd(m) ^ 36'h0_0000_0100;
        st();
        chk({port_a_parity_error_n, port_a_data_oe_n}, 2'h3);
        chk({port_b_parity_error_n, port_b_data_oe_n}, 2'h1);
        port_a_data_in <= w ^ 36'h0_0000_0001;
        st();
        chk(port_a_parity_error_n, 1'b0);
        {port_a_select_n, port_a_direction, port_a_mailbox_choose, port_a_parity_generate} <= 4'h3;
        st();
        chk({port_a_parity_error_n, port_a_data_oe_n}, 2'h2);
        chk(port_a_data_out, podd(m));
        port_a_select_n <= 1'b1;
        port_a_parity_generate <= 1'b0;
        port_a_data_in <= w;
        ahb(1'b1, FMB_REG_CTRL, '0);
        st();
        chk(port_a_parity_error_n, 1'b0);
        $display("parity test done");
        print_verdict();
    end
endmodule
